// ===== hdl/obp_pkg.sv
package obp_pkg;
    // Register byte addresses
    localparam logic [31:0] MODE_ADDR  = 32'h4000_8000;
    localparam logic [31:0] CTRL_ADDR  = 32'h4000_8004;
    localparam logic [31:0] STAT_ADDR  = 32'h4000_8008;
    // Control register field positions
    localparam int CTRL_ENU_POS  = 27;
    localparam int CTRL_BITU_POS = 26;
    localparam int CTRL_ENL_POS  = 25;
    localparam int CTRL_BITL_POS = 24;
    localparam int CTRL_BSU_POS  = 23;
    localparam int CTRL_IXU_LSB  = 20;
    localparam int CTRL_BSL_POS  = 19;
    localparam int CTRL_IXL_LSB  = 16;
    localparam int CTRL_WAD_LSB  = 0;
    // Writable control bits: 27:16 and 12:0
    localparam logic [31:0] CTRL_MASK  = 32'h0fff_1fff;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Mode register field
    localparam int MODE_LSB = 0;
    // Status register field positions
    localparam int STAT_NW_LSB  = 16;
    localparam int STAT_TEU_POS = 15;
    localparam int STAT_TEL_POS = 14;
    localparam int STAT_PEU_POS = 13;
    localparam int STAT_PEL_POS = 12;
    localparam int STAT_FW_LSB  = 8;
    localparam int STAT_ARDY    = 4;
    localparam int STAT_TERR    = 3;
    localparam int STAT_TRDY    = 2;
    localparam int STAT_PERR    = 1;
    localparam int STAT_PRDY    = 0;
    // Ready flags come out of reset set
    localparam logic RDY_RESET = 1'b1;
    // Byte lane bases inside the word {U1,L1,U0,L0}
    localparam logic [4:0] U1_BASE = 5'h18;
    localparam logic [4:0] L1_BASE = 5'h10;
    localparam logic [4:0] U0_BASE = 5'h08;
    localparam logic [4:0] L0_BASE = 5'h00;
    // Operating mode codes
    typedef enum logic [2:0] {
        OBP_STANDBY    = 3'h0,
        OBP_MAN_READ   = 3'h1,
        OBP_MAN_PROG   = 3'h2,
        OBP_AUTO_READ  = 3'h3,
        OBP_AUTO_PROG  = 3'h4
    } obp_mode_t;
endpackage : obp_pkg

// ===== hdl/obp_ctrl.sv
`timescale 1ns/1ps
module obp_ctrl #(
    parameter int WADDR_W = 13,
    parameter int FIFO_W  = 4
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Macrocell bit programming
    output logic                    cell_prog_req,
    output logic [WADDR_W-1:0]      cell_addr,
    output logic [31:0]             cell_bit_mask,
    output logic [31:0]             cell_bit_data,
    input  wire logic               cell_prog_done,
    input  wire logic               cell_fail_upper,
    input  wire logic               cell_fail_lower,
    // Automatic engine
    output logic [2:0]              op_mode,
    output logic                    auto_start,
    input  wire logic               auto_done,
    input  wire logic               auto_bit_busy,
    // Test engine
    output logic                    test_start,
    input  wire logic               test_done,
    input  wire logic               test_fail_upper,
    input  wire logic               test_fail_lower,
    // Datapath counters
    input  wire logic [FIFO_W-1:0]  fifo_word_count,
    input  wire logic [WADDR_W-1:0] remaining_word_count
);

    // Controller sequencing states
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_MANUAL_PROGRAM_MODE = 5'b00010,
        ST_AUTO  = 5'b00100,
        ST_TEST  = 5'b01000,
        ST_DONE  = 5'b10000
    } obp_state_t;

    // Bit position in the 32-bit word for one bank
    function automatic logic [4:0] obp_bit_pos(
        input logic       upper,
        input logic       bsel,
        input logic [2:0] idx
    );
        logic [4:0] base;
        base = upper ? (bsel ? obp_pkg::U1_BASE : obp_pkg::U0_BASE)
                     : (bsel ? obp_pkg::L1_BASE : obp_pkg::L0_BASE);
        return base + {2'h0, idx};
    endfunction : obp_bit_pos

    obp_state_t        state_q;      // Sequencer state
    obp_state_t        state_d;      // Next sequencer state
    logic [31:0]       ctrl_q;       // Bit program control register
    logic [2:0]        mode_q;       // Operating mode field
    logic              ardy_q;       // Auto mode ready
    logic              trdy_q;       // Test ready
    logic              prdy_q;       // Bit program ready (manual)
    logic              terr_q;       // Test error flag
    logic              terr_u_q;     // Upper test error source
    logic              terr_l_q;     // Lower test error source
    logic              perr_q;       // Program error flag
    logic              perr_u_q;     // Upper program error source
    logic              perr_l_q;     // Lower program error source
    logic              req_q;        // Macrocell request level
    logic              astart_q;     // Auto start pulse
    logic              tstart_q;     // Test start pulse
    logic [31:0]       rdata_q;      // Read data register

    // Bus decode
    wire setup_ph  = psel & ~penable;
    wire access_ph = psel & penable;
    wire hit_mode  = (paddr == obp_pkg::MODE_ADDR);
    wire hit_ctrl  = (paddr == obp_pkg::CTRL_ADDR);
    wire hit_stat  = (paddr == obp_pkg::STAT_ADDR);
    wire hit_any   = hit_mode | hit_ctrl | hit_stat;
    wire wr_ok     = access_ph & pwrite;
    // Status has no write decode at all
    wire wr_mode   = wr_ok & hit_mode;
    wire wr_ctrl   = wr_ok & hit_ctrl;
    wire [2:0] new_mode = pwdata[obp_pkg::MODE_LSB +: 3];

    // Control fields
    wire       en_u  = ctrl_q[obp_pkg::CTRL_ENU_POS];
    wire       bit_u = ctrl_q[obp_pkg::CTRL_BITU_POS];
    wire       en_l  = ctrl_q[obp_pkg::CTRL_ENL_POS];
    wire       bit_l = ctrl_q[obp_pkg::CTRL_BITL_POS];
    wire       bs_u  = ctrl_q[obp_pkg::CTRL_BSU_POS];
    wire [2:0] ix_u  = ctrl_q[obp_pkg::CTRL_IXU_LSB +: 3];
    wire       bs_l  = ctrl_q[obp_pkg::CTRL_BSL_POS];
    wire [2:0] ix_l  = ctrl_q[obp_pkg::CTRL_IXL_LSB +: 3];
    wire [WADDR_W-1:0] waddr =
        ctrl_q[obp_pkg::CTRL_WAD_LSB +: WADDR_W];

    // Lanes: upper bank in bits 31:24 and 15:8, lower in 23:16, 7:0
    wire [4:0]  pos_u  = obp_bit_pos(1'b1, bs_u, ix_u);
    wire [4:0]  pos_l  = obp_bit_pos(1'b0, bs_l, ix_l);
    // One bit per enabled bank only
    wire [31:0] mask_u = {31'h0, en_u} << pos_u;
    wire [31:0] mask_l = {31'h0, en_l} << pos_l;
    wire [31:0] dat_u  = {31'h0, bit_u} << pos_u;
    wire [31:0] dat_l  = {31'h0, bit_l} << pos_l;
    // Enables carried by the control write that starts the sequence
    wire        any_en = pwdata[obp_pkg::CTRL_ENU_POS]
                       | pwdata[obp_pkg::CTRL_ENL_POS];

    // Mode decode
    wire is_auto = (new_mode == obp_pkg::OBP_AUTO_READ)
                 | (new_mode == obp_pkg::OBP_AUTO_PROG);
    wire is_test = (new_mode > obp_pkg::OBP_AUTO_PROG);
    wire in_manual_program_mode = (mode_q == obp_pkg::OBP_MAN_PROG);
    wire in_automatic_program_mode = (mode_q == obp_pkg::OBP_AUTO_PROG);
    wire idle     = (state_q == ST_IDLE);
    // Manual programming starts on a control write in manual program mode
    wire go_manual_program_mode = idle & wr_ctrl & in_manual_program_mode;
    wire go_auto  = idle & wr_mode & is_auto;
    wire go_test  = idle & wr_mode & is_test;

    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (go_manual_program_mode) begin
                    // Nothing enabled: finish without touching cells
                    state_d = any_en ? ST_MANUAL_PROGRAM_MODE : ST_DONE;
                end else if (go_auto) begin
                    state_d = ST_AUTO;
                end else if (go_test) begin
                    state_d = ST_TEST;
                end
            end
            ST_MANUAL_PROGRAM_MODE: begin
                if (cell_prog_done) begin
                    state_d = ST_DONE;
                end
            end
            ST_AUTO: begin
                if (auto_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_TEST: begin
                if (test_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Control register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= obp_pkg::CTRL_RESET;
        end else if (wr_ctrl & idle) begin
            // Held stable while a sequence runs
            ctrl_q <= pwdata & obp_pkg::CTRL_MASK;
        end
    end

    // Mode register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= obp_pkg::OBP_STANDBY;
        end else if (wr_mode & idle) begin
            mode_q <= new_mode;
        end
    end

    // Macrocell request and start pulses
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_q    <= 1'b0;
            astart_q <= 1'b0;
            tstart_q <= 1'b0;
        end else begin
            req_q    <= (state_d == ST_MANUAL_PROGRAM_MODE);
            astart_q <= go_auto;
            tstart_q <= go_test;
        end
    end

    // Ready flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ardy_q <= obp_pkg::RDY_RESET;
            trdy_q <= obp_pkg::RDY_RESET;
            prdy_q <= obp_pkg::RDY_RESET;
        end else begin
            ardy_q <= (state_d != ST_AUTO);
            trdy_q <= (state_d != ST_TEST);
            prdy_q <= (state_d != ST_MANUAL_PROGRAM_MODE);
        end
    end

    // Program error flags; the start of a manual program sequence clears them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            perr_q   <= 1'b0;
            perr_u_q <= 1'b0;
            perr_l_q <= 1'b0;
        end else if (go_manual_program_mode) begin
            // No enabled bank reports no error
            perr_q   <= 1'b0;
            perr_u_q <= 1'b0;
            perr_l_q <= 1'b0;
        end else if (cell_prog_done &
                     ((state_q == ST_MANUAL_PROGRAM_MODE) | in_automatic_program_mode)) begin
            // Each bit result; in auto mode the last one stands
            perr_u_q <= cell_fail_upper & en_u;
            perr_l_q <= cell_fail_lower & en_l;
            perr_q   <= (cell_fail_upper & en_u)
                      | (cell_fail_lower & en_l);
        end
    end

    // Test error flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            terr_q   <= 1'b0;
            terr_u_q <= 1'b0;
            terr_l_q <= 1'b0;
        end else if (go_test) begin
            terr_q   <= 1'b0;
            terr_u_q <= 1'b0;
            terr_l_q <= 1'b0;
        end else if ((state_q == ST_TEST) & test_done) begin
            terr_u_q <= test_fail_upper;
            terr_l_q <= test_fail_lower;
            terr_q   <= test_fail_upper | test_fail_lower;
        end
    end

    // Bit program ready in auto program mode follows the engine
    wire prdy_now = prdy_q & ~(in_automatic_program_mode & auto_bit_busy);

    // Status word
    logic [31:0] stat_w;
    always_comb begin
        stat_w = 32'h0;
        stat_w[obp_pkg::STAT_NW_LSB +: WADDR_W] =
            remaining_word_count;
        stat_w[obp_pkg::STAT_TEU_POS] = terr_u_q;
        stat_w[obp_pkg::STAT_TEL_POS] = terr_l_q;
        stat_w[obp_pkg::STAT_PEU_POS] = perr_u_q;
        stat_w[obp_pkg::STAT_PEL_POS] = perr_l_q;
        stat_w[obp_pkg::STAT_FW_LSB +: FIFO_W] =
            fifo_word_count;
        stat_w[obp_pkg::STAT_ARDY] = ardy_q;
        stat_w[obp_pkg::STAT_TERR] = terr_q;
        stat_w[obp_pkg::STAT_TRDY] = trdy_q;
        stat_w[obp_pkg::STAT_PERR] = perr_q;
        stat_w[obp_pkg::STAT_PRDY] = prdy_now;
    end

    // Read mux
    wire [31:0] mode_w = {29'h0, mode_q};
    wire [31:0] rd_mux = hit_mode ? mode_w
                       : hit_ctrl ? ctrl_q
                       : hit_stat ? stat_w
                       : 32'h0;

    // Read data captured in the setup cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 32'h0;
        end else if (setup_ph & ~pwrite) begin
            rdata_q <= rd_mux;
        end
    end

    // Bus answers: no wait states, error on unmapped address
    assign pready  = 1'b1;
    assign pslverr = access_ph & ~hit_any;
    assign prdata  = rdata_q;

    // Macrocell outputs
    assign cell_prog_req = req_q;
    assign cell_addr     = waddr;
    assign cell_bit_mask = mask_u | mask_l;
    assign cell_bit_data = dat_u | dat_l;
    assign op_mode       = mode_q;
    assign auto_start    = astart_q;
    assign test_start    = tstart_q;

endmodule : obp_ctrl

// ===== bench/obp_ctrl_assertions.sv
`timescale 1ns/1ps
module obp_ctrl_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        cell_prog_req,
    input wire logic        cell_prog_done,
    input wire logic [31:0] cell_bit_mask,
    input wire logic [31:0] cell_bit_data,
    input wire logic [2:0]  op_mode,
    input wire logic        auto_start,
    input wire logic        test_start
);
    wire acc   = psel && penable;                 // Access phase
    wire hit_m = paddr == obp_pkg::MODE_ADDR;     // Mode register hit
    wire hit_c = paddr == obp_pkg::CTRL_ADDR;     // Control hit
    wire hit_s = paddr == obp_pkg::STAT_ADDR;     // Status hit
    // Control write while idle in manual program mode
    wire go = acc && pwrite && hit_c && op_mode == 3'h2 && !cell_prog_req;
    // Mode write from standby, never ignored
    wire mw = acc && pwrite && hit_m && op_mode == 3'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    slv_err_a: assert property (acc |-> pslverr == !(hit_m || hit_c || hit_s))
        else $error("slave error mismatch");
    prog_start_a: assert property (go && (pwdata[27] || pwdata[25])
        |=> cell_prog_req) else $error("program did not start");
    no_bank_a: assert property (go && !pwdata[27] && !pwdata[25]
        |=> !cell_prog_req) else $error("program without bank");
    prog_hold_a: assert property (cell_prog_req && !cell_prog_done
        |=> cell_prog_req) else $error("request dropped early");
    prog_end_a: assert property (cell_prog_req && cell_prog_done
        |=> !cell_prog_req) else $error("request stuck");
    one_bit_a: assert property (cell_prog_req |->
        $countones({cell_bit_mask[31:24], cell_bit_mask[15:8]}) <= 1 &&
        $countones({cell_bit_mask[23:16], cell_bit_mask[7:0]}) <= 1)
        else $error("more than one bit per bank");
    lower_pos_a: assert property ($rose(cell_prog_req) && $past(pwdata[25])
        |-> cell_bit_mask[{$past(pwdata[19]), 1'b0, $past(pwdata[18:16])}]
        && cell_bit_data[{$past(pwdata[19]), 1'b0, $past(pwdata[18:16])}]
        == $past(pwdata[24])) else $error("lower bit wrong");
    upper_pos_a: assert property ($rose(cell_prog_req) && $past(pwdata[27])
        |-> cell_bit_mask[{$past(pwdata[23]), 1'b1, $past(pwdata[22:20])}])
        else $error("upper bit wrong");
    mode_set_a: assert property (mw |=> op_mode == $past(pwdata[2:0]))
        else $error("mode not taken");
    auto_go_a: assert property (mw && pwdata[2:0] inside {3'h3, 3'h4}
        |-> ##[1:2] auto_start) else $error("auto start missing");
    test_go_a: assert property (mw && pwdata[2:0] >= 3'h5
        |-> ##[1:2] test_start) else $error("test start missing");
endmodule : obp_ctrl_checker

bind obp_ctrl obp_ctrl_checker chk (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
    .cell_prog_req, .cell_prog_done, .cell_bit_mask, .cell_bit_data,
    .op_mode, .auto_start, .test_start
);

// ===== bench/obp_cell_model.sv
`timescale 1ns/1ps
module obp_cell_model #(
    parameter int DLY = 6
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic cell_prog_req,
    input  wire logic auto_start,
    input  wire logic test_start,
    input  wire logic fail_u,
    input  wire logic fail_l,
    output logic      cell_prog_done,
    output logic      cell_fail_upper,
    output logic      cell_fail_lower,
    output logic      auto_done,
    output logic      auto_bit_busy,
    output logic      test_done,
    output logic      test_fail_upper,
    output logic      test_fail_lower
);
    logic [3:0] cnt_q; // Cycles left in the job
    logic [1:0] job_q; // 0 idle, 1 bit, 2 auto, 3 test
    wire        fin = job_q != 2'h0 && cnt_q == 4'h0;
    // Jobs start from idle and last DLY+1 cycles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            job_q <= 2'h0;
            cnt_q <= 4'h0;
        end else if (job_q == 2'h0) begin
            job_q <= auto_start ? 2'h2 :
                     test_start ? 2'h3 : {1'b0, cell_prog_req};
            cnt_q <= 4'(DLY);
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else begin
            job_q <= 2'h0;
        end
    end
    // One-cycle completion pulses
    assign cell_prog_done  = fin && job_q == 2'h1;
    assign auto_done       = fin && job_q == 2'h2;
    assign test_done       = fin && job_q == 2'h3;
    assign auto_bit_busy   = job_q == 2'h2 && !fin;
    // Fail lines hold meaning only beside a done pulse
    assign cell_fail_upper = cell_prog_done ? fail_u : !fail_u;
    assign cell_fail_lower = cell_prog_done ? fail_l : !fail_l;
    assign test_fail_upper = test_done ? fail_u : !fail_u;
    assign test_fail_lower = test_done ? fail_l : !fail_l;
endmodule : obp_cell_model

// ===== bench/obp_ctrl_tb.sv
`timescale 1ns/1ps
module obp_ctrl_tb;
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rdv, cell_bit_mask, cell_bit_data;
    logic        cell_prog_req, cell_prog_done, cell_fail_upper, er;
    logic        cell_fail_lower, auto_start, auto_done, auto_bit_busy;
    logic        test_start, test_done, test_fail_upper, test_fail_lower;
    logic        fail_u, fail_l;
    logic [12:0] cell_addr, remaining_word_count;
    logic [2:0]  op_mode;
    logic [3:0]  fifo_word_count;
    int          fails, samples_checked;
    // Device under test and far-side engines
    obp_ctrl #(.WADDR_W(13), .FIFO_W(4)) uut (.clk, .rst_b, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cell_prog_req,
        .cell_addr, .cell_bit_mask, .cell_bit_data, .cell_prog_done,
        .cell_fail_upper, .cell_fail_lower, .op_mode, .auto_start,
        .auto_done, .auto_bit_busy, .test_start, .test_done,
        .test_fail_upper, .test_fail_lower, .fifo_word_count,
        .remaining_word_count);
    obp_cell_model #(.DLY(6)) far (.clk, .rst_b, .cell_prog_req,
        .auto_start, .test_start, .fail_u, .fail_l, .cell_prog_done,
        .cell_fail_upper, .cell_fail_lower, .auto_done, .auto_bit_busy,
        .test_done, .test_fail_upper, .test_fail_lower);
    // Free-running clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Compare one value, count and report
    task automatic check(input string nm, input logic [31:0] ex, got);
        samples_checked++;
        if (got !== ex) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : check
    // One APB transfer, released at its completion edge
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Expected status word
    function automatic logic [31:0] sx(logic [1:0] te, pe, logic [4:0] f);
        return {3'h0, remaining_word_count, te, pe, fifo_word_count, 3'h0, f};
    endfunction : sx
    // Poll one status bit under a bound
    task automatic wait_st(input int b, input logic v);
        int n;
        n = 0;
        do begin apb(0, obp_pkg::STAT_ADDR, 0); n++; end
        while (rdv[b] !== v && n < 40);
        check("status ready", v, rdv[b]);
    endtask : wait_st
    // Reset values, read-only status, live counts
    task automatic t_reset;
        apb(0, obp_pkg::STAT_ADDR, 0);
        check("status reset", sx(0, 0, 5'h15), rdv);
        apb(0, obp_pkg::CTRL_ADDR, 0);
        check("control reset", 32'h0, rdv);
        fifo_word_count <= 4'h5;
        remaining_word_count <= 13'h0123;
        apb(1, obp_pkg::STAT_ADDR, 32'hffff_ffff);
        apb(0, obp_pkg::STAT_ADDR, 0);
        check("status write", sx(0, 0, 5'h15), rdv);
    endtask : t_reset
    // Control fields, reserved bits, unmapped place
    task automatic t_regs;
        apb(1, obp_pkg::CTRL_ADDR, 32'hffff_ffff);
        apb(0, obp_pkg::CTRL_ADDR, 0);
        check("control rw", obp_pkg::CTRL_MASK, rdv);
        check("word address", 32'h1fff, 32'(cell_addr));
        apb(0, 32'h4000_8020, 0);
        check("unmapped error", 32'h1, 32'(er));
        apb(1, obp_pkg::CTRL_ADDR, 0);
    endtask : t_regs
    // Manual bit programming: none, both, lower bank only
    task automatic t_manual;
        logic [31:0] cv [3] = '{32'h05f0_0010, 32'h0bf3_1234, 32'h0658_0001};
        logic [31:0] mk [3] = '{32'h0, 32'h8000_0008, 32'h0001_0000};
        logic [31:0] dt [3] = '{32'h0, 32'h0000_0008, 32'h0};
        logic [1:0]  pe [3] = '{2'h0, 2'h2, 2'h1};
        apb(1, obp_pkg::MODE_ADDR, 32'h2);
        for (int i = 0; i < 3; i++) begin
            fail_u <= pe[i][1];
            fail_l <= (i != 1);
            apb(1, obp_pkg::CTRL_ADDR, cv[i]);
            @(negedge clk);
            check("request", 32'(i != 0), 32'(cell_prog_req));
            if (i != 0) begin
                check("bit mask", mk[i], cell_bit_mask);
                check("bit data", dt[i], cell_bit_data & mk[i]);
                check("address", cv[i] & 32'h1fff, 32'(cell_addr));
                wait_st(0, 1'b0);
            end
            wait_st(0, 1'b1);
            check("program result", sx(0, pe[i], {3'h5, pe[i] != 2'h0, 1'b1}), rdv);
        end
        apb(1, obp_pkg::MODE_ADDR, 32'h0);
    endtask : t_manual
    // Mode codes 1 to 5, with engine busy spans and a failing test
    task automatic t_modes;
        int b;
        for (int m = 1; m < 6; m++) begin
            fail_u <= 1'b0;
            fail_l <= (m == 5);
            apb(1, obp_pkg::MODE_ADDR, 32'(m));
            @(negedge clk);
            check("mode", 32'(m), 32'(op_mode));
            if (m >= 3) begin
                b = (m == 5) ? obp_pkg::STAT_TRDY : obp_pkg::STAT_ARDY;
                wait_st(b, 1'b0);
                wait_st(b, 1'b1);
            end
            apb(1, obp_pkg::MODE_ADDR, 32'h0);
        end
        check("test error", 32'h3, 32'({rdv[15:14], rdv[3]}));
    endtask : t_modes
    // Verdict and end of run
    task automatic results;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    // Watchdog against a hung handshake
    initial begin
        #200000;
        fails++;
        results;
    end
    // Reset, then the scenarios in turn
    initial begin
        {rst_b, psel, penable, pwrite, fail_u, fail_l} = 6'h0;
        {paddr, pwdata} = 64'h0;
        fifo_word_count = 4'ha;
        remaining_word_count = 13'h1abc;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_regs;
        t_manual;
        t_modes;
        results;
    end
endmodule : obp_ctrl_tb
